// >>> shared/bmu_pkg.sv
// Purpose: Shared types and constants for the bit-manipulation unit.
// Assumes: Byte operands, eight general registers addressed by index.
// Notes:   Operation codes are internal to the core, not instruction encodings.
package bmu_pkg;

  // --------------------------------------------------------------------
  // Widths and field positions
  // --------------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;  // Operand byte width.
  localparam int unsigned BITNO_W    = 3;  // Bit number field width.
  localparam int unsigned REGIDX_W   = 3;  // General register index width.
  localparam int unsigned ADDR_W     = 8;  // Absolute address width.
  localparam int unsigned NUM_REGS   = 8;  // Number of byte registers.
  localparam int unsigned REG_LSB    = 0;  // Low three bits give the bit number.
  localparam logic [7:0]  REG_RESET  = 8'h00; // Register reset value.

  // --------------------------------------------------------------------
  // Operation codes
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    BMU_BIT_SET_OP                = 4'h0,
    BMU_BIT_CLEAR_OP              = 4'h1,
    BMU_BIT_INVERT_OP             = 4'h2,
    BMU_BIT_TEST_OP               = 4'h3,
    BMU_CARRY_AND_BIT_OP          = 4'h4,
    BMU_CARRY_AND_INVERTED_BIT_OP = 4'h5,
    BMU_CARRY_OR_BIT_OP           = 4'h6,
    BMU_CARRY_OR_INVERTED_BIT_OP  = 4'h7,
    BMU_CARRY_XOR_BIT_OP          = 4'h8,
    BMU_CARRY_XOR_INVERTED_BIT_OP = 4'h9,
    BMU_BIT_TO_CARRY_OP           = 4'hA,
    BMU_INVERTED_BIT_TO_CARRY_OP  = 4'hB,
    BMU_CARRY_TO_BIT_OP           = 4'hC,
    BMU_INVERTED_CARRY_TO_BIT_OP  = 4'hD
  } bmu_op_t;

  // Operand addressing modes.
  typedef enum logic [1:0] {
    BMU_AM_REG_DIRECT   = 2'h0,
    BMU_AM_REG_INDIRECT = 2'h1,
    BMU_AM_ABSOLUTE     = 2'h2
  } bmu_amode_t;

  // Controller states.
  typedef enum logic [1:0] {
    BMU_ST_IDLE  = 2'h0,
    BMU_ST_READ  = 2'h1,
    BMU_ST_WAIT  = 2'h2,
    BMU_ST_WRITE = 2'h3
  } bmu_state_t;

  // One decoded instruction.
  typedef struct packed {
    bmu_op_t    op;        // Operation.
    bmu_amode_t amode;     // Operand addressing mode.
    logic [2:0] opnd_reg;  // Register holding operand or its address.
    logic [7:0] abs_addr;  // Absolute address.
    logic       bit_reg;   // High: bit number from a register.
    logic [2:0] bit_imm;   // Immediate bit number.
    logic [2:0] bit_src;   // Register holding the bit number.
  } bmu_instr_t;

  // Memory request.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bmu_mem_req_t;

  // Condition-code flags kept by the unit.
  typedef struct packed {
    logic c;  // Carry.
    logic z;  // Zero.
  } bmu_flags_t;

endpackage : bmu_pkg

// >>> rtl/bmu_bit_alu.sv
// Purpose: Combinational bit operation on one byte and the carry flag.
// Assumes: Operand byte and bit number are already fetched.
// Notes:   Pure logic; the caller registers every result.
`timescale 1ns/1ps
module bmu_bit_alu (
  input  wire bmu_pkg::bmu_op_t op_in,       // Operation.
  input  wire logic [7:0]       byte_in,     // Operand byte.
  input  wire logic [2:0]       bitno_in,    // Selected bit number.
  input  wire logic             carry_in,    // Current carry flag.
  output logic      [7:0]       byte_out,    // Result byte.
  output logic                  carry_out,   // New carry flag.
  output logic                  zero_out,    // New zero flag.
  output logic                  wr_out,      // High: byte must be written back.
  output logic                  zupd_out,    // High: zero flag updates.
  output logic                  cupd_out     // High: carry flag updates.
);

  // --------------------------------------------------------------------
  // Bit selection and result
  // --------------------------------------------------------------------
  logic [7:0] mask;  // One-hot mask of the selected bit.
  logic       sel;   // Selected operand bit.
  assign mask = 8'h01 << bitno_in;
  assign sel  = byte_in[bitno_in];

  // Every operation is decoded here so the controller stays generic.
  always_comb begin
    byte_out  = byte_in;
    carry_out = carry_in;
    zero_out  = 1'b0;
    wr_out    = 1'b0;
    zupd_out  = 1'b0;
    cupd_out  = 1'b0;
    unique case (op_in)
      bmu_pkg::BMU_BIT_SET_OP: begin
        byte_out = byte_in | mask;
        wr_out   = 1'b1;
      end
      bmu_pkg::BMU_BIT_CLEAR_OP: begin
        byte_out = byte_in & ~mask;
        wr_out   = 1'b1;
      end
      bmu_pkg::BMU_BIT_INVERT_OP: begin
        byte_out = byte_in ^ mask;
        wr_out   = 1'b1;
      end
      bmu_pkg::BMU_BIT_TEST_OP: begin
        zero_out = ~sel;
        zupd_out = 1'b1;
      end
      bmu_pkg::BMU_CARRY_AND_BIT_OP: begin
        carry_out = carry_in & sel;
        cupd_out  = 1'b1;
      end
      bmu_pkg::BMU_CARRY_AND_INVERTED_BIT_OP: begin
        carry_out = carry_in & ~sel;
        cupd_out  = 1'b1;
      end
      bmu_pkg::BMU_CARRY_OR_BIT_OP: begin
        carry_out = carry_in | sel;
        cupd_out  = 1'b1;
      end
      bmu_pkg::BMU_CARRY_OR_INVERTED_BIT_OP: begin
        carry_out = carry_in | ~sel;
        cupd_out  = 1'b1;
      end
      bmu_pkg::BMU_CARRY_XOR_BIT_OP: begin
        carry_out = carry_in ^ sel;
        cupd_out  = 1'b1;
      end
      bmu_pkg::BMU_CARRY_XOR_INVERTED_BIT_OP: begin
        carry_out = carry_in ^ ~sel;
        cupd_out  = 1'b1;
      end
      bmu_pkg::BMU_BIT_TO_CARRY_OP: begin
        carry_out = sel;
        cupd_out  = 1'b1;
      end
      bmu_pkg::BMU_INVERTED_BIT_TO_CARRY_OP: begin
        carry_out = ~sel;
        cupd_out  = 1'b1;
      end
      bmu_pkg::BMU_CARRY_TO_BIT_OP: begin
        byte_out = carry_in ? (byte_in | mask) : (byte_in & ~mask);
        wr_out   = 1'b1;
      end
      bmu_pkg::BMU_INVERTED_CARRY_TO_BIT_OP: begin
        byte_out = carry_in ? (byte_in & ~mask) : (byte_in | mask);
        wr_out   = 1'b1;
      end
      // Codes 4'hE and 4'hF are illegal and change nothing.
      default: begin
        byte_out = byte_in;
      end
    endcase
  end

endmodule : bmu_bit_alu

// >>> rtl/bmu_core.sv
// Purpose: Bit-manipulation datapath with its own byte register file,
//          carry and zero flags, and a memory port for byte operands.
// Assumes: Memory answers a read with rdata_valid_in one or more cycles
//          later and takes a write in the cycle that wr is high.
// Notes:   One instruction at a time; busy_out marks the unit as taken.
//          A start while busy is ignored.
//          Illegal codes give one refusal pulse.
//          Read data may not be valid with the read pulse.
//          Clock enable low stretches every state.
//
// Operation
// - Set selects bit to one.
// - Bit number from immediate, or from register for set, clear, invert and test.
// - Clear forces selected bit to zero.
// - Invert complements the selected bit.
// - Test loads zero with inverted bit.
// - Carry becomes carry AND bit.
// - Carry becomes carry AND inverted bit.
// - Inverted operations use only immediate bit.
// - Carry becomes carry OR bit.
// - Carry becomes carry OR inverted bit.
// - Carry becomes carry XOR bit.
// - Carry becomes carry XOR inverted bit.
// - Bit copied into carry.
// - Inverted bit copied into carry.
// - Carry written into selected bit.
// - Inverted carry written into selected bit.
// - Operand by register, indirect or absolute.
`timescale 1ns/1ps
module bmu_core #(
  parameter int unsigned NUM_REGS = bmu_pkg::NUM_REGS  // Register file depth.
) (
  input  wire logic                 core_clk_in,       // Core clock, 200 MHz.
  input  wire logic                 reset_in,          // Asynchronous reset, high.
  input  wire logic                 clk_en_in,         // Low freezes all state.
  input  wire logic                 start_in,          // Pulse: take instr_in.
  input  wire bmu_pkg::bmu_instr_t  instr_in,          // Decoded instruction.
  input  wire logic                 reg_wr_in,         // Loader write strobe.
  input  wire logic [2:0]           reg_wr_idx_in,     // Loader register index.
  input  wire logic [7:0]           reg_wr_data_in,    // Loader write data.
  input  wire logic                 carry_wr_in,       // Load carry from outside.
  input  wire logic                 carry_data_in,     // Carry value to load.
  input  wire logic [7:0]           mem_rdata_in,      // Memory read data.
  input  wire logic                 mem_rdata_valid_in,// Memory read data valid.
  output bmu_pkg::bmu_mem_req_t     mem_req_out,       // Memory request.
  output bmu_pkg::bmu_flags_t       flags_out,         // Carry and zero flags.
  output logic                      busy_out,          // Instruction in flight.
  output logic                      done_out,          // Pulse: instruction done.
  output logic                      illegal_out        // Pulse: instruction refused.
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  // Each item has a _next twin.
  // Register file.
  logic [7:0]            regs_reg [NUM_REGS];  // Byte register file.
  logic [7:0]            regs_next [NUM_REGS]; // Next register file.

  // Controller state.
  bmu_pkg::bmu_state_t   state_reg;            // Controller state.
  bmu_pkg::bmu_state_t   state_next;

  // Instruction in flight.
  bmu_pkg::bmu_instr_t   ins_reg;              // Latched instruction.
  bmu_pkg::bmu_instr_t   ins_next;
  logic [2:0]            bitno_reg;            // Latched bit number.
  logic [2:0]            bitno_next;
  logic [7:0]            addr_reg;             // Latched memory address.
  logic [7:0]            addr_next;

  // Condition flags.
  bmu_pkg::bmu_flags_t   flags_reg;            // Carry and zero.
  bmu_pkg::bmu_flags_t   flags_next;

  // Memory request, from flops.
  bmu_pkg::bmu_mem_req_t mem_reg;              // Registered memory request.
  bmu_pkg::bmu_mem_req_t mem_next;

  // One-cycle pulses.
  logic                  done_reg;             // Completion pulse.
  logic                  done_next;
  logic                  ill_reg;              // Refusal pulse.
  logic                  ill_next;

  // --------------------------------------------------------------------
  // Shared ALU
  // --------------------------------------------------------------------
  // One shared ALU: one operand at a time.
  // A second copy would only add area.
  // ALU results, used in READ and WAIT.
  logic [7:0] alu_byte_in;   // Operand byte into the ALU.
  logic [7:0] alu_byte;      // Result byte.
  logic       alu_c;         // Result carry.
  logic       alu_z;         // Result zero.
  logic       alu_wr;        // Result must be stored.
  logic       alu_zupd;      // Zero flag updates.
  logic       alu_cupd;      // Carry flag updates.
  logic       inv_op;        // Operation is one of the inverted group.

  // Fed from latched state and the memory read data.
  bmu_bit_alu u_alu (
    .op_in     (ins_reg.op),
    .byte_in   (alu_byte_in),
    .bitno_in  (bitno_reg),
    .carry_in  (flags_reg.c),
    .byte_out  (alu_byte),
    .carry_out (alu_c),
    .zero_out  (alu_z),
    .wr_out    (alu_wr),
    .zupd_out  (alu_zupd),
    .cupd_out  (alu_cupd)
  );

  // Register operands come straight from the file; memory from the read.
  // Memory data is used while valid stands.
  assign alu_byte_in = (ins_reg.amode == bmu_pkg::BMU_AM_REG_DIRECT)
                     ? regs_reg[ins_reg.opnd_reg] : mem_rdata_in;

  // Decoded from the incoming instruction,
  // since refusal is decided on acceptance.
  // inverted group check.
  assign inv_op = (instr_in.op == bmu_pkg::BMU_CARRY_AND_INVERTED_BIT_OP) ||
                  (instr_in.op == bmu_pkg::BMU_CARRY_OR_INVERTED_BIT_OP)  ||
                  (instr_in.op == bmu_pkg::BMU_CARRY_XOR_INVERTED_BIT_OP) ||
                  (instr_in.op == bmu_pkg::BMU_INVERTED_BIT_TO_CARRY_OP)  ||
                  (instr_in.op == bmu_pkg::BMU_INVERTED_CARRY_TO_BIT_OP);

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  // A register operand completes in one cycle after acceptance; a memory
  // operand needs a read, a wait for data and, if modified, a write.
  // Illegal codes are refused in idle.
  always_comb begin
    // Hold by default; pulses drop.
    regs_next  = regs_reg;
    state_next = state_reg;
    ins_next   = ins_reg;
    bitno_next = bitno_reg;
    addr_next  = addr_reg;
    flags_next = flags_reg;
    mem_next   = '0;
    done_next  = 1'b0;
    ill_next   = 1'b0;
    // Loader access to the file and carry, only while idle to avoid races.
    if (reg_wr_in && (state_reg == bmu_pkg::BMU_ST_IDLE)) begin
      regs_next[reg_wr_idx_in] = reg_wr_data_in;
    end
    if (carry_wr_in && (state_reg == bmu_pkg::BMU_ST_IDLE)) begin
      flags_next.c = carry_data_in;
    end

    // One branch per state.
    unique case (state_reg)
      // Idle: wait for a start.
      bmu_pkg::BMU_ST_IDLE: begin
        if (start_in) begin
          // Register-sourced bit number is illegal for the inverted group
          // and for the logic/copy group, which take only an immediate.
          if (instr_in.bit_reg && (inv_op ||
              (instr_in.op > bmu_pkg::BMU_BIT_TEST_OP)) ||
              (instr_in.op > bmu_pkg::BMU_INVERTED_CARRY_TO_BIT_OP) ||
              (instr_in.amode > bmu_pkg::BMU_AM_ABSOLUTE)) begin
            // Refuse: pulse, keep state.
            ill_next = 1'b1;
          end else begin
            // Accept: latch the instruction.
            ins_next = instr_in;
            // The bit number is read now, so a
            // later loader write cannot change it.
            // bit number source.
            bitno_next = instr_in.bit_reg
                       ? regs_reg[instr_in.bit_src][bmu_pkg::REG_LSB +: 3]
                       : instr_in.bit_imm;
            // Register direct keeps the old address.
            // operand address mode.
            unique case (instr_in.amode)
              bmu_pkg::BMU_AM_REG_INDIRECT: addr_next = regs_reg[instr_in.opnd_reg];
              bmu_pkg::BMU_AM_ABSOLUTE:     addr_next = instr_in.abs_addr;
              default:                      addr_next = addr_reg;
            endcase
            state_next = bmu_pkg::BMU_ST_READ;
          end
        end
      end

      // Read: finish or issue a read.
      bmu_pkg::BMU_ST_READ: begin
        if (ins_reg.amode == bmu_pkg::BMU_AM_REG_DIRECT) begin
          // Result, flags and done in one edge.
          if (alu_wr) begin
            regs_next[ins_reg.opnd_reg] = alu_byte;
          end
          if (alu_cupd) begin
            flags_next.c = alu_c;
          end
          if (alu_zupd) begin
            flags_next.z = alu_z;
          end
          done_next  = 1'b1;
          state_next = bmu_pkg::BMU_ST_IDLE;
        end else begin
          // Memory operand: fetch the byte.
          // read whole byte.
          mem_next.rd   = 1'b1;
          mem_next.addr = addr_reg;
          state_next    = bmu_pkg::BMU_ST_WAIT;
        end
      end

      // Wait: use the data while valid.
      bmu_pkg::BMU_ST_WAIT: begin
        if (mem_rdata_valid_in) begin
          // Flags land on the same edge that issues the write or finishes.
          if (alu_cupd) begin
            flags_next.c = alu_c;
          end
          if (alu_zupd) begin
            flags_next.z = alu_z;
          end
          if (alu_wr) begin
            mem_next.wr    = 1'b1;
            mem_next.addr  = addr_reg;
            mem_next.wdata = alu_byte;
            state_next     = bmu_pkg::BMU_ST_WRITE;
          end else begin
            // Read-only: nothing to write.
            done_next  = 1'b1;
            state_next = bmu_pkg::BMU_ST_IDLE;
          end
        end
      end

      // Write: one cycle, then idle.
      bmu_pkg::BMU_ST_WRITE: begin
        // The write was issued on entry; finish here.
        done_next  = 1'b1;
        state_next = bmu_pkg::BMU_ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // Clock enable low holds everything, including pulses, as they stand.
  // Reset branch loads constants only.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      // Register file back to reset value.
      for (int i = 0; i < int'(NUM_REGS); i++) begin
        regs_reg[i] <= bmu_pkg::REG_RESET;
      end

      state_reg <= bmu_pkg::BMU_ST_IDLE;
      ins_reg   <= '0;
      bitno_reg <= 3'h0;
      addr_reg  <= 8'h00;
      flags_reg <= '0;
      mem_reg   <= '0;
      done_reg  <= 1'b0;
      ill_reg   <= 1'b0;
    end else if (clk_en_in) begin
      // Next values land only on enabled edges.
      regs_reg  <= regs_next;
      state_reg <= state_next;
      ins_reg   <= ins_next;
      bitno_reg <= bitno_next;
      addr_reg  <= addr_next;
      flags_reg <= flags_next;
      mem_reg   <= mem_next;
      done_reg  <= done_next;
      ill_reg   <= ill_next;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Busy comes from its own flop, loaded from the next state, so it is glitch free.
  logic busy_reg;  // Registered busy flag.
  logic busy_next;
  // Next busy follows the next state.
  assign busy_next = (state_next != bmu_pkg::BMU_ST_IDLE);

  // Busy tracks the state register one-for-one.
  // Own flop keeps the port off the decode.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_reg <= 1'b0;
    end else if (clk_en_in) begin
      busy_reg <= busy_next;
    end
  end

  // Ports copy flops; no logic after them.
  assign mem_req_out = mem_reg;
  assign flags_out   = flags_reg;
  assign busy_out    = busy_reg;
  assign done_out    = done_reg;
  assign illegal_out = ill_reg;

endmodule : bmu_core

// >>> bench/bmu_core_monitor.sv
// Purpose: Protocol and result assertions for the bit-manipulation core.
// Assumes: Sees only the ports of bmu_core.
// Notes:   Register contents are invisible here, so bit checks use immediates.
`timescale 1ns/1ps
module bmu_core_monitor #(
  parameter int unsigned NUM_REGS = bmu_pkg::NUM_REGS  // Register file depth.
) (
  input wire logic                  core_clk_in,
  input wire logic                  reset_in,
  input wire logic                  clk_en_in,
  input wire logic                  start_in,
  input wire bmu_pkg::bmu_instr_t   instr_in,
  input wire logic [7:0]            mem_rdata_in,
  input wire logic                  mem_rdata_valid_in,
  input wire bmu_pkg::bmu_mem_req_t mem_req_out,
  input wire bmu_pkg::bmu_flags_t   flags_out,
  input wire logic                  busy_out,
  input wire logic                  done_out,
  input wire logic                  illegal_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  logic                legal;     // Instruction is one the core accepts.
  logic                take;      // Start seen while idle.
  logic                modify;    // Captured operation writes its operand.
  bmu_pkg::bmu_instr_t cap_reg;   // Instruction in flight.
  logic [7:0]          rdat_reg;  // Last byte read from memory.
  assign legal = instr_in.op <= 4'hD && instr_in.amode != 2'h3
                 && !(instr_in.bit_reg && instr_in.op > 4'h3);
  assign take = start_in && !busy_out && clk_en_in;
  assign modify = cap_reg.op <= 4'h2 || cap_reg.op >= 4'hC;
  // Capture what the assertions compare against, since bodies are hidden.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cap_reg <= '0;
      rdat_reg <= 8'h00;
    end else begin
      if (take) cap_reg <= instr_in;
      if (mem_rdata_valid_in) rdat_reg <= mem_rdata_in;
    end
  end
  sequence s_take_reg;
    take && legal && instr_in.amode == bmu_pkg::BMU_AM_REG_DIRECT ##1 clk_en_in;
  endsequence
  sequence s_take_mem;
    take && legal && instr_in.amode != bmu_pkg::BMU_AM_REG_DIRECT ##1 clk_en_in;
  endsequence
  a_reg_done_lat: assert property (
    s_take_reg |=> done_out && !busy_out) else $error("register op late");
  a_mem_read_lat: assert property (
    s_take_mem |=> mem_req_out.rd && busy_out) else $error("memory read late");
  a_abs_addr: assert property (
    mem_req_out.rd && cap_reg.amode == bmu_pkg::BMU_AM_ABSOLUTE
    |-> mem_req_out.addr == cap_reg.abs_addr) else $error("absolute address wrong");
  a_illegal_refuse: assert property (
    take && !legal |=> illegal_out && !busy_out) else $error("bad instruction taken");
  a_write_back: assert property (
    mem_rdata_valid_in && busy_out && clk_en_in && modify
    |=> mem_req_out.wr && !done_out) else $error("no write back");
  a_no_write: assert property (
    mem_rdata_valid_in && busy_out && clk_en_in && !modify
    |=> done_out && !mem_req_out.wr) else $error("read-only op wrote");
  a_wr_then_done: assert property (
    mem_req_out.wr && clk_en_in |=> done_out) else $error("done missing");
  a_one_bit_only: assert property (
    mem_req_out.wr && !cap_reg.bit_reg
    |-> ((mem_req_out.wdata ^ rdat_reg) & ~(8'h01 << cap_reg.bit_imm)) == 8'h00)
    else $error("other bits changed");
  a_set_bit: assert property (
    mem_req_out.wr && !cap_reg.bit_reg && cap_reg.op == bmu_pkg::BMU_BIT_SET_OP
    |-> mem_req_out.wdata[cap_reg.bit_imm]) else $error("bit not set");
  a_clear_bit: assert property (
    mem_req_out.wr && !cap_reg.bit_reg && cap_reg.op == bmu_pkg::BMU_BIT_CLEAR_OP
    |-> !mem_req_out.wdata[cap_reg.bit_imm]) else $error("bit not cleared");
  a_flag_isolate: assert property (
    done_out |-> (cap_reg.op == bmu_pkg::BMU_BIT_TEST_OP ? $stable(flags_out.c)
                  : $stable(flags_out.z))) else $error("wrong flag changed");
endmodule : bmu_core_monitor

bind bmu_core bmu_core_monitor #(.NUM_REGS(NUM_REGS)) u_monitor (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .start_in(start_in), .instr_in(instr_in), .mem_rdata_in(mem_rdata_in),
  .mem_rdata_valid_in(mem_rdata_valid_in), .mem_req_out(mem_req_out),
  .flags_out(flags_out), .busy_out(busy_out), .done_out(done_out),
  .illegal_out(illegal_out));

// >>> bench/bit_manipulation_unit_tb.sv
// Purpose: Random self-checking bench for the bit-manipulation core.
// Assumes: Inputs change at the falling edge; outputs are read there.
// Notes:   Registers are seen through indirect addresses on the memory port.
`timescale 1ns/1ps
module bit_manipulation_unit_tb;
  logic core_clk_in, reset_in, clk_en_in, start_in, reg_wr_in, carry_wr_in;
  logic carry_data_in, mem_rdata_valid_in, busy_out, done_out, illegal_out;
  logic [2:0]            reg_wr_idx_in;
  logic [7:0]            reg_wr_data_in, mem_rdata_in;
  bmu_pkg::bmu_instr_t   instr_in, ins;
  bmu_pkg::bmu_mem_req_t mem_req_out;
  bmu_pkg::bmu_flags_t   flags_out;
  logic [7:0]            regs [8];  // Model register file.
  logic                  c_m, z_m;  // Model flags.
  int                    fails, samples_checked, cycles, n;
  integer                seed;

  bmu_core dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .start_in(start_in), .instr_in(instr_in), .reg_wr_in(reg_wr_in),
    .reg_wr_idx_in(reg_wr_idx_in), .reg_wr_data_in(reg_wr_data_in),
    .carry_wr_in(carry_wr_in), .carry_data_in(carry_data_in),
    .mem_rdata_in(mem_rdata_in), .mem_rdata_valid_in(mem_rdata_valid_in),
    .mem_req_out(mem_req_out), .flags_out(flags_out), .busy_out(busy_out),
    .done_out(done_out), .illegal_out(illegal_out));

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Loads a register and the carry together while the core is idle.
  task automatic load(input int i, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_wr_in = 1'b1;
    reg_wr_idx_in = i[2:0];
    reg_wr_data_in = d;
    carry_wr_in = 1'b1;
    carry_data_in = d[0];
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    carry_wr_in = 1'b0;
    regs[i] = d;
    c_m = d[0];
  endtask : load

  // Runs one instruction, acting as memory, and checks it against the model.
  task automatic run(input bmu_pkg::bmu_instr_t ins, input logic hold);
    logic [7:0] mb, opnd, res, addr;
    logic       legal, mem, modw, b;
    int         bn, k, lat, nrd, nwr, o;
    o = ins.op;
    // register bit numbers only for the first four ops.
    legal = o <= 13 && ins.amode != 2'h3 && !(ins.bit_reg && o > 3);
    mem = ins.amode != bmu_pkg::BMU_AM_REG_DIRECT;
    mb = 8'($random(seed));
    bn = ins.bit_reg ? int'(regs[ins.bit_src][2:0]) : int'(ins.bit_imm);
    addr = ins.amode == bmu_pkg::BMU_AM_REG_INDIRECT ? regs[ins.opnd_reg] : ins.abs_addr;
    opnd = mem ? mb : regs[ins.opnd_reg];
    b = opnd[bn];
    res = opnd;
    modw = o <= 2 || o >= 12;
    case (o)
      0: res[bn] = 1'b1;
      1: res[bn] = 1'b0;
      2: res[bn] = !b;
      12: res[bn] = c_m;
      13: res[bn] = !c_m;
      default: res = opnd;
    endcase
    nrd = 0;
    nwr = 0;
    lat = -1;
    mem_rdata_in = mb;
    @(negedge core_clk_in);
    instr_in = ins;
    start_in = 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge core_clk_in);
      // A start held into the busy cycle must be ignored.
      start_in = hold && legal && k == 0;
      mem_rdata_valid_in = lat == 0;
      lat--;
      if (!legal || done_out) break;
      if (mem_req_out.rd) begin
        nrd++;
        chk(mem_req_out.addr, addr);
        chk(8'(k), 8'h01);
        lat = {$random(seed)} % 3;
      end
      if (mem_req_out.wr) begin
        nwr++;
        chk(mem_req_out.wdata, res);
        chk(mem_req_out.addr, addr);
      end
    end
    if (!legal) begin
      chk(illegal_out, 1'b1);
      chk(flags_out, {c_m, z_m});
      return;
    end
    case (o)
      3: z_m = !b;
      4: c_m = c_m & b;
      5: c_m = c_m & !b;
      6: c_m = c_m | b;
      7: c_m = c_m | !b;
      8: c_m = c_m ^ b;
      9: c_m = c_m ^ !b;
      10: c_m = b;
      11: c_m = !b;
      default: ;
    endcase
    if (modw && !mem) regs[ins.opnd_reg] = res;
    if (!mem) chk(8'(k), 8'h01);
    chk(done_out, 1'b1);
    chk(8'(nrd), 8'(mem));
    chk(8'(nwr), 8'(mem && modw));
    chk(flags_out, {c_m, z_m});
  endtask : run

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'hab5b9097;
    {reset_in, clk_en_in} = 2'b11;
    {start_in, reg_wr_in, carry_wr_in, carry_data_in, mem_rdata_valid_in} = 5'h00;
    instr_in = '0;
    reg_wr_idx_in = 3'h0;
    reg_wr_data_in = 8'h00;
    mem_rdata_in = 8'h00;
    {c_m, z_m} = 2'b00;
    repeat (5) @(negedge core_clk_in);
    reset_in = 1'b0;
    chk(flags_out, 8'h00);
    chk(busy_out, 1'b0);
    for (n = 0; n < 8; n++) load(n, 8'($random(seed)));
    // A frozen clock enable must block a carry load.
    clk_en_in = 1'b0;
    carry_wr_in = 1'b1;
    carry_data_in = !c_m;
    @(negedge core_clk_in);
    carry_wr_in = 1'b0;
    clk_en_in = 1'b1;
    chk(flags_out.c, c_m);
    for (n = 0; n < 600; n++) begin
      if (n % 16 == 0) load({$random(seed)} % 8, 8'($random(seed)));
      run(bmu_pkg::bmu_instr_t'(24'($random(seed))), 1'($random(seed)));
    end
    // Every register read back through an indirect test.
    for (n = 0; n < 8; n++) begin
      ins = '0;
      ins.op = bmu_pkg::BMU_BIT_TEST_OP;
      ins.amode = bmu_pkg::BMU_AM_REG_INDIRECT;
      ins.opnd_reg = 3'(n);
      run(ins, 1'b0);
    end
    give_verdict();
  end
endmodule : bit_manipulation_unit_tb
